// file: common/kse_pkg.sv
/*
 event status and enable block: shared constants.
 assumes the programming port decodes a word offset and strobes.
*/
`default_nettype none
package kse_pkg;
   localparam int unsigned EVT_W = 15;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_ENABLE = 12'h008;
   localparam logic [11:0] OFF_CLEAR = 12'h00c;
   localparam logic [14:0] ENABLE_RST = 15'h0000;
   localparam logic [14:0] STATUS_RST = 15'h0000;
   localparam int unsigned BIT_DEST_UNALIGNED = 14;
   localparam int unsigned BIT_HW_OUT_OF_RANGE = 13;
   localparam int unsigned BIT_WR_INVALIDATED = 12;
   localparam int unsigned BIT_MULTI_WRITE = 11;
   localparam int unsigned BIT_INVAL_EXPORT = 10;
   localparam int unsigned BIT_DEST_UNSET = 9;
   localparam int unsigned BIT_COUNT_MISMATCH = 8;
   localparam int unsigned BIT_NOT_LOCKED = 7;
   localparam int unsigned BIT_NOT_READY = 6;
   localparam int unsigned BIT_BUS_ERROR = 5;
   localparam int unsigned BIT_DEST_UNSUP = 4;
   localparam int unsigned BIT_GEN_PARITY = 3;
   localparam int unsigned BIT_RF_PARITY = 2;
   localparam int unsigned BIT_WHILE_BUSY = 1;
   localparam int unsigned BIT_DONE = 0;
endpackage : kse_pkg
`default_nettype wire

// file: design/kse_event_status.sv
/*
 event status, enable and clear registers with the combined interrupt
 and parity error outputs.
 assumes event inputs are single-cycle pulses from the exporter, slot
 storage, generator and register file; register access is a simple
 synchronous strobe port with a word offset, read data one cycle later.
*/
`default_nettype none
// Notes on behaviour
// - unaligned destination address written sets status bit 14.
// - hardware key port write beyond key words sets status bit 13.
// - root-of-trust write to invalidated slot sets status bit 12.
// - any key word written more than once sets status bit 11.
// - invalidating a slot during its export sets status bit 10.
// - unprogrammed destination address sets status bit 9.
// - key word count disagreeing with slot config sets status bit 8.
// - slot not locked sets status bit 7.
// - export request from a not-ready slot sets status bit 6.
// - bus error response during export write sets status bit 5.
// - unsupported destination address sets status bit 4.
// - generator parity error sets bit 3 and raises parity output.
// - register file parity error sets bit 2 and raises parity output.
// - export request while busy sets bit 1; running export continues.
// - finished export sets status bit 0.
// - interrupt high when any status bit and its enable are set.
// - enable register at 0x008, bits 14..0, reset zero.
// - clear register at 0x00c, write one clears, reads zero.
module kse_event_status #(
   parameter int unsigned EVT_W = kse_pkg::EVT_W
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic dest_addr_unaligned,
   input wire logic hw_port_write_out_of_range,
   input wire logic write_to_invalidated_slot,
   input wire logic key_word_multi_write,
   input wire logic invalidate_during_export,
   input wire logic dest_addr_unset,
   input wire logic key_word_count_mismatch,
   input wire logic slot_not_locked,
   input wire logic export_not_ready,
   input wire logic export_bus_error,
   input wire logic dest_addr_unsupported,
   input wire logic generator_parity_error,
   input wire logic regfile_parity_error,
   input wire logic export_while_busy,
   input wire logic export_done,
   output logic irq_o,
   output logic parity_err_o
);
   if (EVT_W != kse_pkg::EVT_W) begin : g_bad_width
      $error("kse_event_status: EVT_W fixed");
   end

   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [EVT_W-1:0] event_status_reg;
   logic [EVT_W-1:0] event_enable_r;
   logic wr_enable;
   logic wr_clear;

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   assign wr_enable = reg_sel && reg_write && hit(reg_addr,
                                                  kse_pkg::OFF_ENABLE);
   assign wr_clear = reg_sel && reg_write && hit(reg_addr,
                                                 kse_pkg::OFF_CLEAR);

   always_comb begin
      evt_set = '0;
      evt_set[kse_pkg::BIT_DEST_UNALIGNED] = dest_addr_unaligned;
      evt_set[kse_pkg::BIT_HW_OUT_OF_RANGE] =
         hw_port_write_out_of_range;
      evt_set[kse_pkg::BIT_WR_INVALIDATED] =
         write_to_invalidated_slot;
      evt_set[kse_pkg::BIT_MULTI_WRITE] = key_word_multi_write;
      evt_set[kse_pkg::BIT_INVAL_EXPORT] = invalidate_during_export;
      evt_set[kse_pkg::BIT_DEST_UNSET] = dest_addr_unset;
      evt_set[kse_pkg::BIT_COUNT_MISMATCH] = key_word_count_mismatch;
      evt_set[kse_pkg::BIT_NOT_LOCKED] = slot_not_locked;
      evt_set[kse_pkg::BIT_NOT_READY] = export_not_ready;
      evt_set[kse_pkg::BIT_BUS_ERROR] = export_bus_error;
      evt_set[kse_pkg::BIT_DEST_UNSUP] = dest_addr_unsupported;
      evt_set[kse_pkg::BIT_GEN_PARITY] = generator_parity_error;
      evt_set[kse_pkg::BIT_RF_PARITY] = regfile_parity_error;
      // flag only; the exporter keeps running its current job
      evt_set[kse_pkg::BIT_WHILE_BUSY] = export_while_busy;
      evt_set[kse_pkg::BIT_DONE] = export_done;
   end

   // write one clears, zero leaves the bit alone
   assign evt_clr = wr_clear ? reg_wdata[EVT_W-1:0] : '0;

   kse_sticky #(
      .WIDTH(EVT_W)
   ) u_sticky (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .set_i(evt_set),
      .clr_i(evt_clr),
      .flag_o(event_status_reg)
   );

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         event_enable_r <= kse_pkg::ENABLE_RST;
      end else if (wr_enable) begin
         event_enable_r <= reg_wdata[EVT_W-1:0];
      end
   end

   // registered so the pin never glitches on status/enable updates
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(event_status_reg & event_enable_r);
      end
   end

   // alarm path ignores the enables on purpose
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         parity_err_o <= 1'b0;
      end else begin
         parity_err_o <= event_status_reg[kse_pkg::BIT_GEN_PARITY] |
                         event_status_reg[kse_pkg::BIT_RF_PARITY];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (reg_sel && !reg_write) begin
         reg_rdata <= '0;
         if (hit(reg_addr, kse_pkg::OFF_STATUS)) begin
            reg_rdata <= {{(kse_pkg::DATA_W-EVT_W){1'b0}},
                          event_status_reg};
         end else if (hit(reg_addr, kse_pkg::OFF_ENABLE)) begin
            reg_rdata <= {{(kse_pkg::DATA_W-EVT_W){1'b0}},
                          event_enable_r};
         end
      end
   end

   // named steps shared by the properties below
   sequence s_event_pending;
      |(event_status_reg & event_enable_r);
   endsequence

   sequence s_event_idle;
      !(|(event_status_reg & event_enable_r));
   endsequence

   sequence s_parity_flagged;
      event_status_reg[kse_pkg::BIT_GEN_PARITY] ||
         event_status_reg[kse_pkg::BIT_RF_PARITY];
   endsequence

   sequence s_parity_quiet;
      !event_status_reg[kse_pkg::BIT_GEN_PARITY] &&
         !event_status_reg[kse_pkg::BIT_RF_PARITY];
   endsequence

   sequence s_read_status;
      reg_sel && !reg_write && (reg_addr == kse_pkg::OFF_STATUS);
   endsequence

   sequence s_read_enable;
      reg_sel && !reg_write && (reg_addr == kse_pkg::OFF_ENABLE);
   endsequence

   sequence s_read_clear;
      reg_sel && !reg_write && (reg_addr == kse_pkg::OFF_CLEAR);
   endsequence

   AST_UNALIGNED_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      dest_addr_unaligned |=>
         event_status_reg[kse_pkg::BIT_DEST_UNALIGNED])
      else $error("unaligned address event not latched");

   AST_SET_WINS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      (dest_addr_unaligned && evt_clr[kse_pkg::BIT_DEST_UNALIGNED])
      |=> event_status_reg[kse_pkg::BIT_DEST_UNALIGNED])
      else $error("set lost against clear");

   AST_RANGE_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      hw_port_write_out_of_range |=>
         event_status_reg[kse_pkg::BIT_HW_OUT_OF_RANGE])
      else $error("out of range event not latched");

   AST_INVALID_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      write_to_invalidated_slot |=>
         event_status_reg[kse_pkg::BIT_WR_INVALIDATED])
      else $error("invalidated slot event not latched");

   AST_MULTI_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      key_word_multi_write |=> event_status_reg[kse_pkg::BIT_MULTI_WRITE])
      else $error("multiple write event not latched");

   AST_INVAL_EXP_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      invalidate_during_export |=> event_status_reg[kse_pkg::BIT_INVAL_EXPORT])
      else $error("invalidate during export not latched");

   AST_UNSET_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      dest_addr_unset |=> event_status_reg[kse_pkg::BIT_DEST_UNSET])
      else $error("unset address event not latched");

   AST_COUNT_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      key_word_count_mismatch |=>
         event_status_reg[kse_pkg::BIT_COUNT_MISMATCH])
      else $error("count mismatch event not latched");

   AST_LOCK_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      slot_not_locked |=> event_status_reg[kse_pkg::BIT_NOT_LOCKED])
      else $error("not locked event not latched");

   AST_READY_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      export_not_ready |=> event_status_reg[kse_pkg::BIT_NOT_READY])
      else $error("not ready event not latched");

   AST_BUS_ERR_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      export_bus_error |=> event_status_reg[kse_pkg::BIT_BUS_ERROR])
      else $error("bus error event not latched");

   AST_UNSUP_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      dest_addr_unsupported |=> event_status_reg[kse_pkg::BIT_DEST_UNSUP])
      else $error("unsupported address event not latched");

   AST_GEN_PAR_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      generator_parity_error |=> event_status_reg[kse_pkg::BIT_GEN_PARITY])
      else $error("generator parity event not latched");

   AST_RF_PAR_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      regfile_parity_error |=> event_status_reg[kse_pkg::BIT_RF_PARITY])
      else $error("regfile parity event not latched");

   AST_BUSY_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      export_while_busy |=> event_status_reg[kse_pkg::BIT_WHILE_BUSY])
      else $error("busy event not latched");

   AST_DONE_SETS: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      export_done |=> event_status_reg[kse_pkg::BIT_DONE])
      else $error("done event not latched");

   AST_STICKY: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      (event_status_reg[kse_pkg::BIT_BUS_ERROR] && !wr_clear)
      |=> event_status_reg[kse_pkg::BIT_BUS_ERROR])
      else $error("status dropped without clear");

   AST_CLEAR: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      (wr_clear && reg_wdata[kse_pkg::BIT_NOT_READY] && !export_not_ready)
      |=> !event_status_reg[kse_pkg::BIT_NOT_READY])
      else $error("clear had no effect");

   AST_IRQ: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_event_pending |=> irq_o)
      else $error("interrupt missing");

   AST_NO_IRQ: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_event_idle |=> !irq_o)
      else $error("spurious interrupt");

   AST_PARITY: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      generator_parity_error |=> ##1 parity_err_o)
      else $error("parity output not raised");

   AST_RF_PARITY: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      regfile_parity_error |=> ##1 parity_err_o)
      else $error("regfile parity not raised");

   AST_PARITY_OUT: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_parity_flagged |=> parity_err_o)
      else $error("parity output missing for set status");

   AST_PARITY_QUIET: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_parity_quiet |=> !parity_err_o)
      else $error("parity output without parity status");

   AST_ENABLE_WR: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      wr_enable |=> event_enable_r == $past(reg_wdata[EVT_W-1:0]))
      else $error("enable write lost");

   AST_ENABLE_HOLD: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      !wr_enable |=> $stable(event_enable_r))
      else $error("enable changed without a write");

   AST_ENABLE_READ: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_read_enable |=> reg_rdata ==
         {{(kse_pkg::DATA_W-EVT_W){1'b0}}, $past(event_enable_r)})
      else $error("enable read back wrong");

   AST_STATUS_READ: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_read_status |=> reg_rdata ==
         {{(kse_pkg::DATA_W-EVT_W){1'b0}}, $past(event_status_reg)})
      else $error("status read back wrong");

   AST_CLEAR_READ: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      s_read_clear |=> reg_rdata == '0)
      else $error("clear register did not read zero");

   AST_UPPER_ZERO: assert property (@(posedge sys_clk)
      disable iff (!arst_n)
      reg_rdata[kse_pkg::DATA_W-1:EVT_W] == '0)
      else $error("reserved read bits not zero");

   // every bit of the row behaves alike, so check them all
   genvar b;
   generate
      for (b = 0; b < EVT_W; b++) begin : g_bit_chk
         AST_BIT_HOLDS: assert property (@(posedge sys_clk)
            disable iff (!arst_n)
            (event_status_reg[b] && !evt_clr[b]) |=> event_status_reg[b])
            else $error("status bit dropped without clear");
         AST_BIT_CLEARS: assert property (@(posedge sys_clk)
            disable iff (!arst_n)
            (evt_clr[b] && !evt_set[b]) |=> !event_status_reg[b])
            else $error("status bit not cleared");
      end
   endgenerate
endmodule : kse_event_status
`default_nettype wire

// file: design/kse_sticky.sv
/*
 one row of write-one-to-clear sticky event flags.
 assumes events and clears are single-cycle, synchronous to sys_clk.
*/
`default_nettype none
module kse_sticky #(
   parameter int unsigned WIDTH = 15
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clr_i,
   output logic [WIDTH-1:0] flag_o
);
   if (WIDTH < 1) begin : g_bad_width
      $error("kse_sticky: WIDTH must be at least 1");
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         // set beats clear so a coincident event is never lost
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               flag_o[g] <= 1'b0;
            end else if (set_i[g]) begin
               flag_o[g] <= 1'b1;
            end else if (clr_i[g]) begin
               flag_o[g] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule : kse_sticky
`default_nettype wire

// file: verification/test_key_unit_event_status.sv
/*
 self-checking bench for the event status and enable block.
 assumes the strobe register port and pulse event inputs of the notes.
*/
`default_nettype none
module test_key_unit_event_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic reg_sel = 1'b0;
   logic reg_write = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic [14:0] ev = 15'h0;
   logic [31:0] reg_rdata, rd_m, ex, r;
   logic irq_o, parity_err_o, irq_m, par_m;
   logic [14:0] st_m, en_m, clr_m;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   logic quiet = 1'b0;
   always #5 sys_clk = ~sys_clk;
   kse_event_status dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .dest_addr_unaligned(ev[14]), .hw_port_write_out_of_range(ev[13]),
      .write_to_invalidated_slot(ev[12]), .key_word_multi_write(ev[11]),
      .invalidate_during_export(ev[10]), .dest_addr_unset(ev[9]),
      .key_word_count_mismatch(ev[8]), .slot_not_locked(ev[7]),
      .export_not_ready(ev[6]), .export_bus_error(ev[5]),
      .dest_addr_unsupported(ev[4]), .generator_parity_error(ev[3]),
      .regfile_parity_error(ev[2]), .export_while_busy(ev[1]),
      .export_done(ev[0]), .irq_o(irq_o), .parity_err_o(parity_err_o));
   function automatic logic [31:0] exp_read(input logic [11:0] a,
         input logic [14:0] s, input logic [14:0] e);
      case (a)
         kse_pkg::OFF_STATUS: return {17'h0, s};
         kse_pkg::OFF_ENABLE: return {17'h0, e};
         default: return 32'h0;
      endcase
   endfunction : exp_read
   // reference model, set wins over clear as the designer chose
   assign clr_m = (reg_sel && reg_write && reg_addr == kse_pkg::OFF_CLEAR) ?
      reg_wdata[14:0] : 15'h0;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_m <= kse_pkg::STATUS_RST;
         en_m <= kse_pkg::ENABLE_RST;
         irq_m <= 1'b0;
         par_m <= 1'b0;
         rd_m <= 32'h0;
      end else begin
         irq_m <= |(st_m & en_m);
         par_m <= st_m[3] | st_m[2];
         st_m <= (st_m & ~clr_m) | ev;
         if (reg_sel && !reg_write)
            rd_m <= exp_read(reg_addr, st_m, en_m);
         if (reg_sel && reg_write && reg_addr == kse_pkg::OFF_ENABLE)
            en_m <= reg_wdata[14:0];
      end
   end
   task automatic chk_word(input string n, input logic [31:0] e,
         input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   // outputs are levels, so compare every cycle mid-period
   always @(negedge sys_clk) begin
      chk_bit("irq_o", irq_m, irq_o);
      chk_bit("parity_err_o", par_m, parity_err_o);
      chk_word("reg_rdata", rd_m, reg_rdata);
   end
   task automatic acc(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge sys_clk);
      reg_sel <= 1'b1;
      reg_write <= w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_sel <= 1'b0;
   endtask : acc
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(32'hb68c));
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      acc(1'b0, kse_pkg::OFF_ENABLE, 32'h0);
      acc(1'b0, 12'h010, 32'h0);
      acc(1'b1, kse_pkg::OFF_ENABLE, 32'hffff_ffff);
      for (int i = 0; i < 15; i++) begin
         acc(1'b1, kse_pkg::OFF_CLEAR, 32'hffff_ffff);
         ev <= 15'h1 << i;
         @(posedge sys_clk);
         ev <= 15'h0;
         acc(1'b0, kse_pkg::OFF_STATUS, 32'h0);
         #1;
         ex = 32'h1 << i;
         if (i < 8)
            chk_word("st", ex, reg_rdata);
         else
            chk_word("st", ex, reg_rdata);
      end
      // random traffic, unmapped offsets and back-to-back strobes included
      for (int n = 0; n < 3000; n++) begin
         @(posedge sys_clk);
         r = $urandom();
         // idle around the mid-run reset so no request meets its release
         quiet = (n >= 1999 && n <= 2003);
         ev <= (r[3:1] == 3'h0 && !quiet) ? 15'($urandom()) : 15'h0;
         reg_sel <= r[4] && !quiet;
         reg_write <= r[5];
         reg_addr <= (r[7:6] == 2'h3) ? r[31:20] : {8'h0, r[7:6] + 2'h1, 2'h0};
         reg_wdata <= $urandom();
         if (n == 2000)
            arst_n <= 1'b0;
         if (n == 2003)
            arst_n <= 1'b1;
      end
      @(posedge sys_clk);
      reg_sel <= 1'b0;
      ev <= 15'h0;
      repeat (4) @(posedge sys_clk);
      tally_and_finish();
   end
endmodule : test_key_unit_event_status
`default_nettype wire
